// *** design/zpb_cfg.svh ***
// constants for the zero-page bit operation unit
`ifndef ZPB_CFG_SVH
`define ZPB_CFG_SVH
`define ZPB_GRP_MASK 8'h0f
`define ZPB_GRP_CLR 8'h07
`define ZPB_GRP_SET 8'h87
`define ZPB_GRP_BRZ 8'h0f
`define ZPB_GRP_BRO 8'h8f
`define ZPB_BIT_LSB 4
`define ZPB_KIND_BIT 3
`define ZPB_POL_BIT 7
`define ZPB_BRANCH_LEN 16'h0003
`define ZPB_ZP_HIGH 8'h00
`define ZPB_PC_RST 16'h0000
`endif

// *** design/zpb_pkg.sv ***
// types for the zero-page bit operation unit
package zpb_pkg;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_READ = 7'h04,
		ST_WRITE = 7'h08,
		ST_DISP = 7'h10,
		ST_DONE = 7'h20,
		ST_FETCH = 7'h40
	} zpb_state_e;
	// bus request toward zero page
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic rd;
		logic wr;
		logic rmw;
	} zpb_bus_s;
	// finished-instruction report
	typedef struct packed {
		logic [15:0] next_pc;
		logic done;
		logic taken;
	} zpb_done_s;
endpackage

// *** design/zpb_unit.sv ***
// zero-page bit set/clear and bit-test-branch execution unit
// Contract
// - reads inside a read-modify-write flag the port so it returns its data register.
// - the set operation forces one chosen bit of the zero-page byte to one, others kept.
// - the opcode byte holds operation and bit number; the next byte is the zero-page address.
// - the clear operation uses the same format and sequence but writes zero.
// - bit tests take the bit from a three-bit opcode field and read from the second-byte address.
// - the third byte is a displacement; branch on a one bit, else continue in sequence.
// - branch-if-zero shares the format but branches only when the bit is zero.
`include "zpb_cfg.svh"
module zpb_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [15:0] op_pc,
	input wire logic [7:0] rdata,
	input wire logic rvalid,
	output logic busy,
	output zpb_pkg::zpb_bus_s bus,
	output zpb_pkg::zpb_done_s result
);
	zpb_pkg::zpb_state_e st_q, st_d;
	logic [7:0] op_q, op_d;
	logic [15:0] pc_q, pc_d;
	logic [7:0] zp_q, zp_d;
	logic tbit_q, tbit_d;
	zpb_pkg::zpb_bus_s bus_q, bus_d;
	zpb_pkg::zpb_done_s res_q, res_d;

	// true for any opcode of the four added operations, each with eight bit numbers
	function automatic logic is_bitop(input logic [7:0] op);
		is_bitop = ((op & `ZPB_GRP_MASK) == (`ZPB_GRP_CLR & `ZPB_GRP_MASK))
			|| ((op & `ZPB_GRP_MASK) == (`ZPB_GRP_BRZ & `ZPB_GRP_MASK));
	endfunction
	// selects the single bit named by the opcode field
	function automatic logic [7:0] bit_mask(input logic [7:0] op);
		bit_mask = 8'h01 << op[`ZPB_BIT_LSB +: 3];
	endfunction
	// the kind bit splits bit tests from set/clear
	function automatic logic is_branch(input logic [7:0] op);
		is_branch = op[`ZPB_KIND_BIT];
	endfunction

	assign busy = (st_q != zpb_pkg::ST_IDLE);
	assign bus = bus_q;
	assign result = res_q;

	// sequence: fetch address byte, read target, write or fetch displacement
	always_comb begin
		st_d = st_q;
		op_d = op_q;
		pc_d = pc_q;
		zp_d = zp_q;
		tbit_d = tbit_q;
		bus_d = '0;
		res_d = '0;
		case (st_q)
			zpb_pkg::ST_IDLE: begin
				if (start && is_bitop(opcode)) begin
					op_d = opcode;
					pc_d = op_pc + 16'h0001;
					bus_d.addr = op_pc + 16'h0001;
					bus_d.rd = 1'b1;
					st_d = zpb_pkg::ST_ADDR;
				end
			end
			zpb_pkg::ST_ADDR: begin
				bus_d = bus_q;
				if (rvalid) begin
					zp_d = rdata;
					bus_d.addr = {`ZPB_ZP_HIGH, rdata};
					bus_d.rd = 1'b1;
					bus_d.rmw = !is_branch(op_q);
					st_d = zpb_pkg::ST_READ;
				end
			end
			zpb_pkg::ST_READ: begin
				bus_d = bus_q;
				if (rvalid) begin
					tbit_d = |(rdata & bit_mask(op_q));
					if (is_branch(op_q)) begin
						bus_d.addr = pc_q + 16'h0001;
						bus_d.rd = 1'b1;
						bus_d.rmw = 1'b0;
						st_d = zpb_pkg::ST_DISP;
					end else begin
						bus_d.rd = 1'b0;
						bus_d.wr = 1'b1;
						bus_d.addr = {`ZPB_ZP_HIGH, zp_q};
						bus_d.rmw = 1'b1;
						if (op_q[`ZPB_POL_BIT])
							bus_d.wdata = rdata | bit_mask(op_q);
						else
							bus_d.wdata = rdata & ~bit_mask(op_q);
						st_d = zpb_pkg::ST_WRITE;
					end
				end
			end
			zpb_pkg::ST_WRITE: begin
				res_d.done = 1'b1;
				res_d.next_pc = pc_q + 16'h0001;
				st_d = zpb_pkg::ST_IDLE;
			end
			zpb_pkg::ST_DISP: begin
				bus_d = bus_q;
				if (rvalid) begin
					bus_d = '0;
					res_d.done = 1'b1;
					// branch when the bit matches the opcode polarity
					res_d.taken = (tbit_q == op_q[`ZPB_POL_BIT]);
					if (tbit_q == op_q[`ZPB_POL_BIT])
						res_d.next_pc = pc_q - 16'h0001 + `ZPB_BRANCH_LEN
							+ {{8{rdata[7]}}, rdata};
					else
						res_d.next_pc = pc_q - 16'h0001 + `ZPB_BRANCH_LEN;
					st_d = zpb_pkg::ST_IDLE;
				end
			end
			default: st_d = zpb_pkg::ST_IDLE;
		endcase
	end

	// registers, synchronous active-low reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_q <= zpb_pkg::ST_IDLE;
			op_q <= 8'h00;
			pc_q <= `ZPB_PC_RST;
			zp_q <= 8'h00;
			tbit_q <= 1'b0;
			bus_q <= '0;
			res_q <= '0;
		end else begin
			st_q <= st_d;
			op_q <= op_d;
			pc_q <= pc_d;
			zp_q <= zp_d;
			tbit_q <= tbit_d;
			bus_q <= bus_d;
			res_q <= res_d;
		end
	end

	// rmw marker must accompany every set/clear write
	property p_rmw_write;
		@(posedge clk) disable iff (!rst_n) bus.wr |-> bus.rmw;
	endproperty
	a_rmw_write: assert property (p_rmw_write) else $error("write without rmw");

	// set writes back the byte read with the chosen bit forced high
	property p_set_bit;
		@(posedge clk) disable iff (!rst_n)
		(st_q == zpb_pkg::ST_READ && rvalid && op_q[`ZPB_POL_BIT] && !op_q[`ZPB_KIND_BIT])
			|=> (bus.wdata == ($past(rdata) | bit_mask(op_q)));
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("set bit wrong");

	// the second byte becomes the zero-page read address
	property p_zp_addr;
		@(posedge clk) disable iff (!rst_n)
		(st_q == zpb_pkg::ST_ADDR && rvalid)
			|=> (bus.addr == {`ZPB_ZP_HIGH, $past(rdata)} && bus.rd);
	endproperty
	a_zp_addr: assert property (p_zp_addr) else $error("zero page address wrong");

	// clear writes back the byte read with the chosen bit forced low
	property p_clr_bit;
		@(posedge clk) disable iff (!rst_n)
		(st_q == zpb_pkg::ST_READ && rvalid && !op_q[`ZPB_POL_BIT] && !op_q[`ZPB_KIND_BIT])
			|=> (bus.wdata == ($past(rdata) & ~bit_mask(op_q)));
	endproperty
	a_clr_bit: assert property (p_clr_bit) else $error("clear bit wrong");

	// the tested bit is the one named by the opcode field
	property p_test_bit;
		@(posedge clk) disable iff (!rst_n)
		(st_q == zpb_pkg::ST_READ && rvalid && op_q[`ZPB_KIND_BIT])
			|=> (tbit_q == $past(rdata[op_q[`ZPB_BIT_LSB +: 3]]));
	endproperty
	a_test_bit: assert property (p_test_bit) else $error("tested bit wrong");

	// an untaken test continues after its three bytes
	property p_not_taken;
		@(posedge clk) disable iff (!rst_n)
		(result.done && !result.taken && op_q[`ZPB_KIND_BIT])
			|-> (result.next_pc == pc_q + 16'h0002);
	endproperty
	a_not_taken: assert property (p_not_taken) else $error("fallthrough pc wrong");

	// the opcode polarity bit picks which bit value branches
	property p_polarity;
		@(posedge clk) disable iff (!rst_n)
		(result.done && op_q[`ZPB_KIND_BIT])
			|-> (result.taken == (tbit_q == op_q[`ZPB_POL_BIT]));
	endproperty
	a_polarity: assert property (p_polarity) else $error("branch polarity wrong");

	// a taken test adds the signed displacement to the following pc
	property p_target;
		@(posedge clk) disable iff (!rst_n)
		(st_q == zpb_pkg::ST_DISP && rvalid && tbit_q == op_q[`ZPB_POL_BIT])
			|=> (result.next_pc == pc_q + 16'h0002 + {{8{$past(rdata[7])}}, $past(rdata)});
	endproperty
	a_target: assert property (p_target) else $error("branch target wrong");

	// the single write of set/clear is followed at once by the finish report
	property p_one_write;
		@(posedge clk) disable iff (!rst_n) bus.wr |=> (!bus.wr && result.done);
	endproperty
	a_one_write: assert property (p_one_write) else $error("write not single");

	// the write goes back to the zero-page byte that was read
	property p_zp_write;
		@(posedge clk) disable iff (!rst_n) bus.wr |-> (bus.addr == {`ZPB_ZP_HIGH, zp_q});
	endproperty
	a_zp_write: assert property (p_zp_write) else $error("write address wrong");

	// a read request stands unchanged until it is answered
	property p_rd_hold;
		@(posedge clk) disable iff (!rst_n)
		(bus.rd && !rvalid) |=> (bus.rd && $stable(bus.addr));
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");

	// set/clear continue after their two bytes
	property p_seq_pc;
		@(posedge clk) disable iff (!rst_n)
		(result.done && !op_q[`ZPB_KIND_BIT]) |-> (result.next_pc == pc_q + 16'h0001);
	endproperty
	a_seq_pc: assert property (p_seq_pc) else $error("set/clear next pc wrong");
endmodule

// *** bench/zpb_mem.sv ***
// zero-page memory and port model behind the unit's bus
module zpb_mem (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] slow,
	input zpb_pkg::zpb_bus_s bus,
	output logic [7:0] rdata,
	output logic rvalid
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535];
	logic [1:0] wait_q;
	// answer after slow extra cycles; port pins differ from their data register
	always @(posedge clk) begin
		rvalid <= 1'b0;
		rdata <= ~rdata; // released bus keeps changing
		if (!rst_n) begin
			wait_q <= 2'h0;
			rdata <= 8'h00;
		end else if (bus.rd && !rvalid) begin
			if (wait_q == slow) begin
				rvalid <= 1'b1;
				rdata <= (bus.addr < 16'h0040 && !bus.rmw) ? mem[bus.addr] ^ 8'h5a : mem[bus.addr];
				wait_q <= 2'h0;
			end else begin
				wait_q <= wait_q + 2'h1;
			end
		end
		if (bus.wr) begin
			mem[bus.addr] <= bus.wdata;
		end
	end
endmodule

// *** bench/tb_top.sv ***
// random and corner-case bench for the bit operation unit
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic start = 1'b0;
	logic [7:0] opcode = 8'h00;
	logic [15:0] op_pc = 16'h0000;
	logic [1:0] slow = 2'h0;
	logic [31:0] seed = 32'h065a4ecb;
	logic [7:0] rdata;
	logic rvalid;
	logic busy;
	zpb_pkg::zpb_bus_s bus;
	zpb_pkg::zpb_done_s result;
	int n_fail = 0;
	int checks = 0;
	int cycles = 0;
	zpb_unit dut (.clk(clk), .rst_n(rst_n), .start(start), .opcode(opcode), .op_pc(op_pc),
		.rdata(rdata), .rvalid(rvalid), .busy(busy), .bus(bus), .result(result));
	zpb_mem mem (.clk(clk), .rst_n(rst_n), .slow(slow), .bus(bus), .rdata(rdata), .rvalid(rvalid));
	initial forever #25 clk = ~clk;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task end_of_test;
		if (n_fail == 0 && checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// expected test outcome: a branch reads the pins, so a port byte shows its pins
	function automatic logic exp_taken(input logic [7:0] op, input logic [7:0] zp,
		input logic [7:0] val);
		logic [7:0] t;
		t = (zp < 8'h40) ? val ^ 8'h5a : val;
		return t[op[6:4]] == op[7];
	endfunction
	// expected byte after set or clear of the chosen bit
	function automatic logic [7:0] exp_byte(input logic [7:0] op, input logic [7:0] val);
		logic [7:0] m;
		m = 8'h01 << op[6:4];
		return op[7] ? val | m : val & ~m;
	endfunction
	// expected next pc: two bytes for set/clear, three for a test plus a taken displacement
	function automatic logic [15:0] exp_pc(input logic [7:0] op, input logic [15:0] pc,
		input logic tk, input logic [7:0] disp);
		return op[3] ? pc + 16'h0003 + (tk ? {{8{disp[7]}}, disp} : 16'h0000)
			: pc + 16'h0002;
	endfunction
	// cut a hang short
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			end_of_test();
		end
	end
	// one instruction through the unit, expectations worked out here
	task automatic run(input logic [7:0] op, input logic [15:0] pc, input logic [7:0] zp,
		input logic [7:0] val, input logic [7:0] disp);
		logic tk;
		int k;
		mem.mem[pc + 16'h1] = zp;
		mem.mem[pc + 16'h2] = disp;
		mem.mem[{8'h00, zp}] = val;
		tk = exp_taken(op, zp, val);
		@(negedge clk);
		start = 1'b1;
		opcode = op;
		op_pc = pc;
		@(negedge clk);
		// the unit is busy now, so this changed request must be ignored
		chk({15'h0000, busy}, 16'h0001);
		opcode = op ^ 8'h80;
		op_pc = pc + 16'h0100;
		@(negedge clk);
		start = 1'b0;
		for (k = 0; k < 40 && result.done !== 1'b1; k++) @(negedge clk);
		chk({15'h0000, result.done}, 16'h0001);
		if (op[3]) begin
			chk({15'h0000, result.taken}, {15'h0000, tk});
			chk(result.next_pc, exp_pc(op, pc, tk, disp));
		end else begin
			chk(result.next_pc, exp_pc(op, pc, tk, disp));
			chk({8'h00, mem.mem[{8'h00, zp}]}, {8'h00, exp_byte(op, val)});
		end
		@(negedge clk);
	endtask
	// reset, a refused opcode, then corner cases and random instructions
	initial begin
		logic [31:0] r;
		logic [31:0] q;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		start = 1'b1;
		opcode = 8'hea;
		@(negedge clk);
		start = 1'b0;
		chk({15'h0000, busy}, 16'h0000);
		for (int i = 0; i < 48; i++) begin
			r = rnd();
			q = rnd();
			slow = r[25:24];
			run({i < 8 ? i[1] : r[7], i < 8 ? i[2:0] : r[6:4], i[0] ? 4'hf : 4'h7},
				{2'b10, q[13:0]}, i == 0 ? 8'h00 : i == 1 ? 8'hff : r[15:8], r[23:16],
				i == 5 ? 8'h80 : i == 3 ? 8'h7f : q[21:14]);
		end
		end_of_test();
	end
endmodule
